// ### bench/tpc_load.sv
`timescale 1ns/10ps
module tpc_load (
   input  wire logic        clk,      // Bus clock
   input  wire logic        rst_b,    // Async reset, active low
   input  wire logic [1:0]  pin,      // Driven PWM pins
   input  wire logic        clr,      // Restart the tallies
   output logic [1:0][15:0] hi_cnt,   // Cycles seen high
   output logic [1:0][15:0] rise_cnt  // Rising edges seen
);
   logic [1:0] last_pin;
   // ------------------------------
   // Load view of each pin
   // ------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hi_cnt   <= '0;
         rise_cnt <= '0;
         last_pin <= '0;
      end else begin
         last_pin <= pin;
         for (int i = 0; i < 2; i++) begin
            hi_cnt[i]   <= clr ? 16'h0000 : hi_cnt[i] + {15'h0000, pin[i]};
            rise_cnt[i] <= clr ? 16'h0000 : rise_cnt[i] + {15'h0000, pin[i] & ~last_pin[i]};
         end
      end
   end
endmodule

// ### bench/tpc_top_properties.sv
`timescale 1ns/10ps
`include "tpc_defines.svh"
module tpc_top_properties
   import tpc_pkg::*;
(
   input wire logic          clk,      // Bus clock
   input wire logic          rst_b,    // Async reset, active low
   input tpc_pkg::tpc_axi_req_t axi_req, // Master side
   input tpc_pkg::tpc_axi_rsp_t axi_rsp, // Slave side
   input wire logic [1:0]    pwm_out,  // Channel pins
   input wire logic          irq_ovf,  // Overflow request
   input wire logic [1:0]    irq_chan  // Channel requests
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_write_resp;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
         |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid;
   endproperty
   a_write_resp: assert property (p_write_resp) else $error("write response late");
   property p_read_resp;
      axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
   endproperty
   a_read_resp: assert property (p_read_resp) else $error("read response late");
   property p_bdone;
      axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid;
   endproperty
   a_bdone: assert property (p_bdone) else $error("write response repeated");
   property p_rdone;
      axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid;
   endproperty
   a_rdone: assert property (p_rdone) else $error("read response repeated");
   property p_wr_refuse;
      axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
   endproperty
   a_wr_refuse: assert property (p_wr_refuse) else $error("write taken during response");
   property p_rd_refuse;
      axi_rsp.rvalid |-> !axi_rsp.arready;
   endproperty
   a_rd_refuse: assert property (p_rd_refuse) else $error("read taken during response");
   property p_unmapped;
      axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 8'h1C
         |=> axi_rsp.rresp == `TPC_RESP_SLVERR && axi_rsp.rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_ovf_level;
      $fell(irq_ovf) |-> axi_rsp.bvalid;
   endproperty
   a_ovf_level: assert property (p_ovf_level) else $error("overflow request dropped");
   property p_chan_level;
      $fell(irq_chan[0]) |-> axi_rsp.bvalid;
   endproperty
   a_chan_level: assert property (p_chan_level) else $error("channel request dropped");
endmodule
bind tpc_top tpc_top_properties u_props (.clk(clk), .rst_b(rst_b), .axi_req(axi_req),
   .axi_rsp(axi_rsp), .pwm_out(pwm_out), .irq_ovf(irq_ovf), .irq_chan(irq_chan));

// ### bench/tpc_top_tb.sv
`timescale 1ns/10ps
`include "tpc_defines.svh"
module tpc_top_tb;
   import tpc_pkg::*;
   logic clk, rst_b, clr, irq_ovf;
   tpc_axi_req_t req;
   tpc_axi_rsp_t rsp;
   logic [1:0] pwm_out, irq_chan, rs;
   logic [1:0][15:0] hi, rise;
   logic [31:0] rdat;
   logic [15:0] h3, h6;
   int n_mismatch, total_checks, cyc;
   tpc_top DUT (.clk(clk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp),
      .pwm_out(pwm_out), .irq_ovf(irq_ovf), .irq_chan(irq_chan));
   tpc_load u_load (.clk(clk), .rst_b(rst_b), .pin(pwm_out), .clr(clr),
      .hi_cnt(hi), .rise_cnt(rise));
   always #50 clk = ~clk;
   // ------------------------------
   // Bus and compare helpers
   // ------------------------------
   task automatic chk(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.bready  <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clk);
         aw = req.awvalid & rsp.awready;
         w  = req.wvalid & rsp.wready;
         b  = rsp.bvalid;
         rs = rsp.bresp;
         @(posedge clk);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
      end
      req.bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      logic ar, v;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      v = 1'b0;
      while (!v) begin
         @(negedge clk);
         ar   = req.arvalid & rsp.arready;
         v    = rsp.rvalid;
         rdat = rsp.rdata;
         rs   = rsp.rresp;
         @(posedge clk);
         if (ar) req.arvalid <= 1'b0;
      end
      req.rready <= 1'b0;
   endtask
   task automatic meas();
      repeat (30) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (100) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic setup(input logic [7:0] sc, cm, input logic [15:0] cmp, input logic [7:0] ctl);
      wr(`TPC_OFF_CTL, 32'h30);
      wr(`TPC_OFF_PER, 32'h9);
      wr(cm, {16'h0000, cmp});
      wr(sc, {24'h000000, ctl});
      wr(`TPC_OFF_CTL, 32'h0);
      meas();
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_regs();
      rdr(`TPC_OFF_CTL);
      chk("ctl reset", 32'h20, rdat);
      rdr(`TPC_OFF_PER);
      chk("period reset", 32'hFFFF, rdat);
      rdr(8'h1C);
      chk("unmapped rresp", {30'h0, `TPC_RESP_SLVERR}, {30'h0, rs});
      wr(8'h1C, 32'h1);
      chk("unmapped bresp", {30'h0, `TPC_RESP_SLVERR}, {30'h0, rs});
   endtask
   task automatic t_halt();
      logic [31:0] first;
      wr(`TPC_OFF_CTL, 32'h0);
      repeat (20) @(posedge clk);
      wr(`TPC_OFF_CTL, 32'h20);
      rdr(`TPC_OFF_CNT);
      first = rdat;
      repeat (20) @(posedge clk);
      rdr(`TPC_OFF_CNT);
      chk("count moved", 32'h1, {31'h0, first != 32'h0});
      chk("count held", first, rdat);
      wr(`TPC_OFF_CTL, 32'h30);
      rdr(`TPC_OFF_CNT);
      chk("count cleared", 32'h0, rdat);
   endtask
   task automatic t_ovf();
      wr(`TPC_OFF_PER, 32'h4);
      wr(`TPC_OFF_CTL, 32'h0);
      repeat (20) @(posedge clk);
      wr(`TPC_OFF_CTL, 32'h20);
      rdr(`TPC_OFF_CTL);
      chk("ovf flag", 32'hA0, rdat);
      chk("ovf irq masked", 32'h0, {31'h0, irq_ovf});
      wr(`TPC_OFF_CTL, 32'h60);
      chk("ovf irq raised", 32'h1, {31'h0, irq_ovf});
      wr(`TPC_OFF_CTL, 32'hE0);
      chk("ovf irq cleared", 32'h0, {31'h0, irq_ovf});
   endtask
   task automatic t_pwm();
      setup(`TPC_OFF_C0SC, `TPC_OFF_C0CMP, 16'h3, 8'h1A);
      chk("rises", 32'hA, {16'h0, rise[0]});
      h3 = hi[0];
      setup(`TPC_OFF_C0SC, `TPC_OFF_C0CMP, 16'h6, 8'h1A);
      chk("width step", {16'h0, h3} + 32'h1E, {16'h0, hi[0]});
      h6 = hi[0];
      setup(`TPC_OFF_C0SC, `TPC_OFF_C0CMP, 16'h6, 8'h1E);
      chk("set action", 32'h64, {16'h0, hi[0]} + {16'h0, h6});
      setup(`TPC_OFF_C0SC, `TPC_OFF_C0CMP, 16'h6, 8'h18);
      chk("no toggle", 32'h0, {16'h0, hi[0]});
      setup(`TPC_OFF_C0SC, `TPC_OFF_C0CMP, 16'h6, 8'h1B);
      chk("full duty", 32'h64, {16'h0, hi[0]});
      rdr(`TPC_OFF_C0SC);
      chk("event flag", 32'h9B, rdat);
      chk("chan irq masked", 32'h0, {31'h0, irq_chan[0]});
      wr(`TPC_OFF_C0SC, 32'h5B);
      chk("chan irq raised", 32'h1, {31'h0, irq_chan[0]});
   endtask
   task automatic t_link();
      setup(`TPC_OFF_C1SC, `TPC_OFF_C1CMP, 16'h6, 8'h6A);
      chk("chan1 mode 10", {16'h0, h6}, {16'h0, hi[1]});
      chk("chan1 irq raised", 32'h1, {31'h0, irq_chan[1]});
      wr(`TPC_OFF_C1CMP, 32'h6);
      setup(`TPC_OFF_C0SC, `TPC_OFF_C0CMP, 16'h3, 8'hBA);
      chk("linked width", {16'h0, h3}, {16'h0, hi[0]});
      chk("chan1 silent", 32'h0, {hi[1], rise[1]});
      rdr(`TPC_OFF_C0SC);
      chk("pair status", 32'hBA, rdat);
      wr(`TPC_OFF_C1CMP, 32'h6);
      meas();
      chk("swapped width", {16'h0, h6}, {16'h0, hi[0]});
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      clr = 1'b0;
      req = '0;
      req.wstrb = 4'hF;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_halt();
      t_ovf();
      t_pwm();
      t_link();
      give_verdict();
   end
endmodule

// ### src/tpc_channel.sv
`timescale 1ns/10ps
`include "tpc_defines.svh"

module tpc_channel (
   input  wire logic                  clk,       // Bus clock
   input  wire logic                  rst_b,     // Async reset, active low
   input  tpc_pkg::tpc_chan_cfg_t     cfg,       // Channel configuration
   input  wire logic                  enable,    // Channel drives its pin
   input  wire logic [`TPC_CNT_W-1:0] cmp_value, // Effective pulse width
   input  wire logic [`TPC_CNT_W-1:0] counter,   // Timer count
   input  wire logic                  tick,      // Prescaled count strobe
   input  wire logic                  ovf,       // Counter wrap strobe
   output logic                       pwm,       // Channel output pin
   output logic                       match      // Compare event strobe
);
   import tpc_pkg::*;

   logic full_hold;

   assign match     = enable && tick && (counter == cmp_value);
   assign full_hold = cfg.full_duty && cfg.tov;

   // ----------------------------------------------------------------
   // Output pin
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm <= 1'b0;
      end else if (!enable) begin
         pwm <= 1'b0;
      end else if (full_hold) begin
         pwm <= 1'b1;
      end else if (match) begin
         case (cfg.action)
            TPC_ACT_CLEAR:  pwm <= 1'b0;
            TPC_ACT_SET:    pwm <= 1'b1;
            TPC_ACT_TOGGLE: pwm <= ~pwm;
            default:        pwm <= pwm;
         endcase
      end else if (ovf && cfg.tov) begin
         pwm <= ~pwm;
      end
   end

endmodule

// ### src/tpc_defines.svh
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define TPC_ADDR_W      8
`define TPC_OFF_CTL     8'h00
`define TPC_OFF_CNT     8'h04
`define TPC_OFF_PER     8'h08
`define TPC_OFF_C0SC    8'h0C
`define TPC_OFF_C0CMP   8'h10
`define TPC_OFF_C1SC    8'h14
`define TPC_OFF_C1CMP   8'h18

// ----------------------------------------------------------------------
// Timer status/control fields
// ----------------------------------------------------------------------
`define TPC_CTL_OVF     7
`define TPC_CTL_OIE     6
`define TPC_CTL_HALT    5
`define TPC_CTL_CLR     4
`define TPC_CTL_PS_HI   2
`define TPC_CTL_PS_LO   0

// ----------------------------------------------------------------------
// Channel status/control fields
// ----------------------------------------------------------------------
`define TPC_CSC_FLAG    7
`define TPC_CSC_IE      6
`define TPC_CSC_MU      5
`define TPC_CSC_ML      4
`define TPC_CSC_AU      3
`define TPC_CSC_AL      2
`define TPC_CSC_TOV     1
`define TPC_CSC_MAX     0

// ----------------------------------------------------------------------
// Widths, reset values, responses
// ----------------------------------------------------------------------
`define TPC_CNT_W       16
`define TPC_PS_W        7
`define TPC_PS_ONE      8'h01
`define TPC_CNT_ZERO    16'h0000
`define TPC_CNT_ONE     16'h0001
`define TPC_PER_RST     16'hFFFF
`define TPC_CMP_RST     16'h0000
`define TPC_PS_RST      3'h0
`define TPC_HALT_RST    1'b1
`define TPC_RESP_OKAY   2'b00
`define TPC_RESP_SLVERR 2'b10

`endif

// ### src/tpc_pkg.sv
`include "tpc_defines.svh"

package tpc_pkg;

   // -------------------------------------------------------------------
   // Bus carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic                   awvalid;
      logic [`TPC_ADDR_W-1:0] awaddr;
      logic                   wvalid;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   bready;
      logic                   arvalid;
      logic [`TPC_ADDR_W-1:0] araddr;
      logic                   rready;
   } tpc_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tpc_axi_rsp_t;

   // -------------------------------------------------------------------
   // Channel configuration
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      TPC_ACT_NONE   = 2'b00,
      TPC_ACT_TOGGLE = 2'b01,
      TPC_ACT_CLEAR  = 2'b10,
      TPC_ACT_SET    = 2'b11
   } tpc_action_t;

   typedef struct packed {
      logic        irq_en;
      logic [1:0]  mode;
      tpc_action_t action;
      logic        tov;
      logic        full_duty;
   } tpc_chan_cfg_t;

   typedef enum logic [1:0] {
      TPC_WR_ACCEPT = 2'b00,
      TPC_WR_RESP   = 2'b01
   } tpc_wr_state_t;

endpackage

// ### src/tpc_top.sv
// Function
// - Halt bit freezes the counter value
// - Clear bit zeroes counter and prescaler
// - Period limit sets the wrap count
// - Compare match changes the channel output
// - Mode 01 unbuffered, 10 buffered on channel 0 only
// - Overflow toggle bit toggles output on wrap
// - Action 10 clears, 11 sets on compare
// - Channel 0 upper mode bit links pair
// - Linked pair starts from channel 0 compare
// - Channel 0 control governs linked output
// - Upper mode bit beats lower mode bit
// - No overflow toggle with clear action gives 0% duty
// - Full duty plus toggle holds output high
// - Overflow flag sets at period limit
// - Overflow enable gates overflow interrupt
// - Compare sets the channel event flag
// - Channel interrupt only when enable set
`timescale 1ns/10ps
`include "tpc_defines.svh"

module tpc_top (
   input  wire logic          clk,       // Bus clock, 10 MHz
   input  wire logic          rst_b,     // Async reset, active low
   input  tpc_pkg::tpc_axi_req_t axi_req, // AXI4-Lite master signals
   output tpc_pkg::tpc_axi_rsp_t axi_rsp, // AXI4-Lite slave signals
   output logic [1:0]         pwm_out,   // Channel output pins
   output logic               irq_ovf,   // Overflow interrupt request
   output logic [1:0]         irq_chan   // Channel interrupt requests
);
   import tpc_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   tpc_wr_state_t          wr_state_reg;
   logic                   aw_held_reg;
   logic [`TPC_ADDR_W-1:0] aw_addr_reg;
   logic                   w_held_reg;
   logic [31:0]            w_data_reg;
   logic [3:0]             w_strb_reg;
   logic [1:0]             bresp_reg;
   logic                   rvalid_reg;
   logic [31:0]            rdata_reg;
   logic [1:0]             rresp_reg;

   logic                   ovf_flag_reg;
   logic                   ovf_ie_reg;
   logic                   halt_reg;
   logic [2:0]             ps_sel_reg;
   logic [`TPC_PS_W-1:0]   ps_cnt_reg;
   logic [`TPC_CNT_W-1:0]  cnt_reg;
   logic [`TPC_CNT_W-1:0]  period_reg;
   logic [`TPC_CNT_W-1:0]  cmp_reg [2];
   tpc_chan_cfg_t          cfg_reg [2];
   logic [1:0]             flag_reg;
   logic                   buf_sel_reg;
   logic                   buf_pend_reg;
   logic                   buf_pend_next;

   logic                   do_write;
   logic                   wr_ctl;
   logic                   wr_per;
   logic [1:0]             wr_csc;
   logic [1:0]             wr_cmp;
   logic                   wr_hit;
   logic                   wr_clear;
   logic [7:0]             wb0;
   logic [7:0]             wb1;
   logic                   ar_fire;
   logic [31:0]            rd_data_next;
   logic [1:0]             rd_resp_next;

   logic [`TPC_PS_W-1:0]   ps_mask;
   logic                   tick;
   logic                   ovf;
   logic                   linked;
   logic [1:0]             chan_en;
   logic [1:0]             match;
   logic [`TPC_CNT_W-1:0]  eff_cmp [2];

   // ----------------------------------------------------------------
   // AXI4-Lite handshake
   // ----------------------------------------------------------------
   assign axi_rsp.awready = (wr_state_reg == TPC_WR_ACCEPT) && !aw_held_reg;
   assign axi_rsp.wready  = (wr_state_reg == TPC_WR_ACCEPT) && !w_held_reg;
   assign axi_rsp.bvalid  = (wr_state_reg == TPC_WR_RESP);
   assign axi_rsp.bresp   = bresp_reg;
   assign axi_rsp.arready = !rvalid_reg;
   assign axi_rsp.rvalid  = rvalid_reg;
   assign axi_rsp.rdata   = rdata_reg;
   assign axi_rsp.rresp   = rresp_reg;

   assign do_write = (wr_state_reg == TPC_WR_ACCEPT) && aw_held_reg && w_held_reg;
   assign ar_fire  = axi_req.arvalid && !rvalid_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (axi_rsp.awready && axi_req.awvalid) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= axi_req.awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         w_held_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (axi_rsp.wready && axi_req.wvalid) begin
         w_held_reg <= 1'b1;
         w_data_reg <= axi_req.wdata;
         w_strb_reg <= axi_req.wstrb;
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_state_reg <= TPC_WR_ACCEPT;
         bresp_reg    <= `TPC_RESP_OKAY;
      end else begin
         case (wr_state_reg)
            TPC_WR_ACCEPT: begin
               if (do_write) begin
                  wr_state_reg <= TPC_WR_RESP;
                  bresp_reg    <= wr_hit ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
               end
            end
            TPC_WR_RESP: begin
               if (axi_req.bready) begin
                  wr_state_reg <= TPC_WR_ACCEPT;
               end
            end
            default: wr_state_reg <= TPC_WR_ACCEPT;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   assign wr_ctl    = do_write && (aw_addr_reg == `TPC_OFF_CTL);
   assign wr_per    = do_write && (aw_addr_reg == `TPC_OFF_PER);
   assign wr_csc[0] = do_write && (aw_addr_reg == `TPC_OFF_C0SC);
   assign wr_csc[1] = do_write && (aw_addr_reg == `TPC_OFF_C1SC);
   assign wr_cmp[0] = do_write && (aw_addr_reg == `TPC_OFF_C0CMP);
   assign wr_cmp[1] = do_write && (aw_addr_reg == `TPC_OFF_C1CMP);
   assign wr_hit    = (aw_addr_reg == `TPC_OFF_CTL)   || (aw_addr_reg == `TPC_OFF_CNT)
                   || (aw_addr_reg == `TPC_OFF_PER)   || (aw_addr_reg == `TPC_OFF_C0SC)
                   || (aw_addr_reg == `TPC_OFF_C0CMP) || (aw_addr_reg == `TPC_OFF_C1SC)
                   || (aw_addr_reg == `TPC_OFF_C1CMP);
   assign wb0       = w_data_reg[7:0];
   assign wb1       = w_data_reg[15:8];
   assign wr_clear  = wr_ctl && w_strb_reg[0] && wb0[`TPC_CTL_CLR];

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      rd_data_next = '0;
      rd_resp_next = `TPC_RESP_OKAY;
      case (axi_req.araddr)
         `TPC_OFF_CTL: begin
            rd_data_next[`TPC_CTL_OVF]                  = ovf_flag_reg;
            rd_data_next[`TPC_CTL_OIE]                  = ovf_ie_reg;
            rd_data_next[`TPC_CTL_HALT]                 = halt_reg;
            rd_data_next[`TPC_CTL_PS_HI:`TPC_CTL_PS_LO] = ps_sel_reg;
         end
         `TPC_OFF_CNT:   rd_data_next[`TPC_CNT_W-1:0] = cnt_reg;
         `TPC_OFF_PER:   rd_data_next[`TPC_CNT_W-1:0] = period_reg;
         `TPC_OFF_C0SC:  rd_data_next[7:0] = {flag_reg[0], cfg_reg[0]};
         `TPC_OFF_C0CMP: rd_data_next[`TPC_CNT_W-1:0] = cmp_reg[0];
         `TPC_OFF_C1SC:  rd_data_next[7:0] = {flag_reg[1], cfg_reg[1]};
         `TPC_OFF_C1CMP: rd_data_next[`TPC_CNT_W-1:0] = cmp_reg[1];
         default:        rd_resp_next = `TPC_RESP_SLVERR;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= `TPC_RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_data_next;
         rresp_reg  <= rd_resp_next;
      end else if (rvalid_reg && axi_req.rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Timer control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ovf_ie_reg <= 1'b0;
         halt_reg   <= `TPC_HALT_RST;
         ps_sel_reg <= `TPC_PS_RST;
      end else if (wr_ctl && w_strb_reg[0]) begin
         ovf_ie_reg <= wb0[`TPC_CTL_OIE];
         halt_reg   <= wb0[`TPC_CTL_HALT];
         ps_sel_reg <= wb0[`TPC_CTL_PS_HI:`TPC_CTL_PS_LO];
      end
   end

   // Write one clears; a wrap in the same cycle wins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ovf_flag_reg <= 1'b0;
      end else if (ovf) begin
         ovf_flag_reg <= 1'b1;
      end else if (wr_ctl && w_strb_reg[0] && wb0[`TPC_CTL_OVF]) begin
         ovf_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and counter
   // ----------------------------------------------------------------
   assign ps_mask = `TPC_PS_W'((`TPC_PS_ONE << ps_sel_reg) - `TPC_PS_ONE);
   assign tick    = !halt_reg && (ps_cnt_reg == ps_mask);
   assign ovf     = tick && (cnt_reg == period_reg);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ps_cnt_reg <= '0;
      end else if (wr_clear) begin
         ps_cnt_reg <= '0;
      end else if (tick) begin
         ps_cnt_reg <= '0;
      end else if (!halt_reg) begin
         ps_cnt_reg <= ps_cnt_reg + `TPC_PS_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= `TPC_CNT_ZERO;
      end else if (wr_clear) begin
         cnt_reg <= `TPC_CNT_ZERO;
      end else if (ovf) begin
         cnt_reg <= `TPC_CNT_ZERO;
      end else if (tick) begin
         cnt_reg <= cnt_reg + `TPC_CNT_ONE;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         period_reg <= `TPC_PER_RST;
      end else if (wr_per) begin
         if (w_strb_reg[0]) period_reg[7:0]  <= wb0;
         if (w_strb_reg[1]) period_reg[15:8] <= wb1;
      end
   end

   // ----------------------------------------------------------------
   // Channel registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 2; i++) begin
            cmp_reg[i] <= `TPC_CMP_RST;
            cfg_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_cmp[i] && w_strb_reg[0]) cmp_reg[i][7:0]  <= wb0;
            if (wr_cmp[i] && w_strb_reg[1]) cmp_reg[i][15:8] <= wb1;
            if (wr_csc[i] && w_strb_reg[0]) cfg_reg[i] <= wb0[6:0];
         end
      end
   end

   // Event flags: hardware set beats software clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_reg <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (match[i]) begin
               flag_reg[i] <= 1'b1;
            end else if (wr_csc[i] && w_strb_reg[0] && wb0[`TPC_CSC_FLAG]) begin
               flag_reg[i] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Linked pair buffering
   // ----------------------------------------------------------------
   assign linked = cfg_reg[0].mode[1];

   always_comb begin
      buf_pend_next = buf_pend_reg;
      if (wr_cmp[0]) buf_pend_next = 1'b0;
      if (wr_cmp[1]) buf_pend_next = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         buf_pend_reg <= 1'b0;
         buf_sel_reg  <= 1'b0;
      end else if (!linked) begin
         buf_pend_reg <= 1'b0;
         buf_sel_reg  <= 1'b0;
      end else begin
         buf_pend_reg <= buf_pend_next;
         if (ovf) buf_sel_reg <= buf_pend_next;
      end
   end

   assign eff_cmp[0] = linked ? cmp_reg[buf_sel_reg] : cmp_reg[0];
   assign eff_cmp[1] = cmp_reg[1];
   assign chan_en[0] = (cfg_reg[0].mode != 2'b00);
   assign chan_en[1] = !linked && (cfg_reg[1].mode != 2'b00);

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   tpc_channel u_chan0 (
      .clk       (clk),
      .rst_b     (rst_b),
      .cfg       (cfg_reg[0]),
      .enable    (chan_en[0]),
      .cmp_value (eff_cmp[0]),
      .counter   (cnt_reg),
      .tick      (tick),
      .ovf       (ovf),
      .pwm       (pwm_out[0]),
      .match     (match[0])
   );

   tpc_channel u_chan1 (
      .clk       (clk),
      .rst_b     (rst_b),
      .cfg       (cfg_reg[1]),
      .enable    (chan_en[1]),
      .cmp_value (eff_cmp[1]),
      .counter   (cnt_reg),
      .tick      (tick),
      .ovf       (ovf),
      .pwm       (pwm_out[1]),
      .match     (match[1])
   );

   // ----------------------------------------------------------------
   // Interrupt requests
   // ----------------------------------------------------------------
   assign irq_ovf     = ovf_flag_reg && ovf_ie_reg;
   assign irq_chan[0] = flag_reg[0] && cfg_reg[0].irq_en;
   assign irq_chan[1] = flag_reg[1] && cfg_reg[1].irq_en;

endmodule
